// ===== hdl/ee_buf2.sv
module ee_buf2 (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input ee_pkg::ee_byte_t in_i,
    output logic in_ready_o,
    output ee_pkg::ee_byte_t out_o,
    input wire logic out_ready_i
);
    import ee_pkg::*;

    logic [7:0] slot [2];
    logic [1:0] cnt;
    logic rd_ptr;
    logic wr_ptr;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // handshakes are combinational; full and empty come from the count
    assign in_ready_o = (cnt != 2'd2);
    assign push = in_i.valid && in_ready_o;
    assign pop = out_o.valid && out_ready_i;
    assign out_o.valid = (cnt != 2'd0);
    assign out_o.data = slot[rd_ptr]; // slots are flip-flops

    // storage and pointers
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slot[0] <= 8'h00;
            slot[1] <= 8'h00;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            cnt <= 2'd0;
        end else begin
            if (push) begin
                slot[wr_ptr] <= in_i.data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            cnt <= cnt + 2'(push) - 2'(pop);
        end
    end

endmodule : ee_buf2

// ===== hdl/ee_cfg.svh
`ifndef EE_CFG_SVH
`define EE_CFG_SVH

// instruction codes; bit 3 of the read and write codes carries address bit 8
`define EE_OP_WREN 8'h06
`define EE_OP_WRDI 8'h04
`define EE_OP_RDSR 8'h05
`define EE_OP_WRSR 8'h01
`define EE_OP_READ 8'h03
`define EE_OP_WRITE 8'h02
`define EE_OP_A8_MASK 8'hf7
`define EE_OP_A8_BIT 3

// block protect lower bounds
`define EE_PROT_QUARTER 9'h180
`define EE_PROT_HALF 9'h100

// reset values; synchroniser stages start at the idle pin levels so no false edge follows reset
`define EE_BP_RST 2'h0
`define EE_SYNC_RST 5'h13

// timing
`define EE_CLK_NS 10
`define EE_T_WP_NS 10000000
`define EE_MIN_DESELECT_TIME_NS 240

`endif

// ===== hdl/ee_pkg.sv
package ee_pkg;

    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_RD = 3'b010,
        ST_WR = 3'b011,
        ST_RDSR = 3'b100,
        ST_WRSR = 3'b101,
        ST_SKIP = 3'b110
    } ee_state_t;

    typedef struct packed {
        logic [1:0] bp;
        logic wel;
        logic busy;
    } ee_status_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ee_byte_t;

endpackage : ee_pkg

// ===== hdl/ee_top.sv
// Functional notes
// [R1] every instruction, address and data transfer is a whole 8-bit word.
// [R2] mode 1 link: bits are launched on the rising clock edge and sampled on the falling edge.
// [R3] the array holds 4096 bits as 512 bytes selected by a nine-bit address.
// [R4] the host keeps the serial clock at or below 2.1 MHz.
// [R5] while suspend is asserted no bits are taken and the transfer resumes on release.
// [R6] programming only happens while write protect is high; when low, program operations are refused.
// [R7] the write-enable latch clears itself when a program operation completes.
// [R8] each program cycle is timed internally and needs no erase or setup first.
// [R9] single byte, full 16-byte page and partial page writes are all supported.
// [R10] one self-timed program cycle writes one to four bytes together.
// [R11] four block protect levels set in the status register keep protected bytes unchanged.
// [R12] status reads answer with a busy flag while programming runs.
// [R13] the host holds select high for the minimum deselect time between instructions.
// [R14] the device responds only while its own select is low.
// [R15] a write with the latch clear or to a protected block leaves the array alone and starts no cycle.
`include "ee_cfg.svh"

module ee_top #(
    parameter int WP_CYCLES = `EE_T_WP_NS / `EE_CLK_NS
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    output ee_pkg::ee_status_t status_o
);
    import ee_pkg::*;

    localparam logic [19:0] WP_LAST = 20'(WP_CYCLES - 1);

    logic [4:0] sync1, sync2;
    logic sck_d;
    logic cs_s, sck_s, si_s, hold_s, wp_s, cs_d;
    logic active, sck_rise, sck_fall, cs_rise;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh, tx_sh, tx_next;
    logic tx_pending, tx_load, tx_take;
    ee_byte_t rx_in, rx_out;
    logic rx_in_ready, rx_ready, rx_take;
    ee_state_t state;
    logic [8:0] addr;
    logic is_rd, sr_got, prog_go, prog_sr, wel_set, wel_clr;
    logic [1:0] sr_new, bp;
    logic wel, busy;
    logic [7:0] page_buf [16];
    logic [15:0] mask;
    logic [3:0] quad_any;
    logic [1:0] quad;
    logic [19:0] timer;
    logic prog_tick, prog_done;
    logic [7:0] mem [512];
    logic [7:0] op;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: only the second stage and the delayed copy are read
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= `EE_SYNC_RST;
            sync2 <= `EE_SYNC_RST;
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sync1 <= {cs_n_i, sck_i, si_i, hold_n_i, wp_n_i};
            sync2 <= sync1;
            sck_d <= sck_s;
            cs_d <= cs_s;
        end
    end

    assign {cs_s, sck_s, si_s, hold_s, wp_s} = sync2;
    assign active = !cs_s && hold_s; // [R14] [R5]
    assign sck_rise = active && sck_s && !sck_d;
    assign sck_fall = active && !sck_s && sck_d;
    assign cs_rise = cs_s && !cs_d;

    ////////////////////////////////////////////////////////////////////////
    // receive: sample on falling edges, a byte every eight bits
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt <= 3'd0;
            rx_sh <= 8'h00;
        end else if (cs_s) begin
            bit_cnt <= 3'd0; // a partial byte is dropped at deselect [R1]
        end else if (sck_fall) begin
            rx_sh <= {rx_sh[6:0], si_s}; // [R2]
            bit_cnt <= bit_cnt + 3'd1;
        end
    end

    // a full buffer cannot stall the host clock, so the byte is lost then
    assign rx_in.valid = sck_fall && (bit_cnt == 3'd7) && rx_in_ready; // [R1]
    assign rx_in.data = {rx_sh[6:0], si_s};

    ee_buf2 u_buf (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .in_i(rx_in),
        .in_ready_o(rx_in_ready),
        .out_o(rx_out),
        .out_ready_i(rx_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit: launch on rising edges, next byte taken at a byte boundary
    assign tx_take = sck_rise && (bit_cnt == 3'd0);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_sh <= 8'h00;
            so_o <= 1'b0;
        end else if (cs_s) begin
            tx_sh <= 8'h00;
        end else if (tx_take) begin
            so_o <= tx_next[7]; // [R2]
            tx_sh <= {tx_next[6:0], 1'b0};
        end else if (sck_rise) begin
            so_o <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    // output floats while deselected or suspended
    assign so_oe_o = active; // [R14] [R5]

    // set wins over take, so a fresh byte is never skipped
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_pending <= 1'b0;
        end else if (tx_load) begin
            tx_pending <= 1'b1;
        end else if (tx_take || cs_s) begin
            tx_pending <= 1'b0;
        end
    end

    // reading states wait until the previous answer byte has left
    assign rx_ready = !(tx_pending && (state == ST_RD || state == ST_RDSR));
    assign rx_take = rx_out.valid && rx_ready;
    assign op = rx_out.data;
    assign tx_load = rx_take && !cs_rise && (state == ST_RD || state == ST_RDSR ||
        (state == ST_ADDR && is_rd) || (state == ST_CMD && op == `EE_OP_RDSR));

    function automatic logic is_prot(input logic [8:0] a, input logic [1:0] lvl);
        case (lvl)
            2'd0: is_prot = 1'b0;
            2'd1: is_prot = (a >= `EE_PROT_QUARTER);
            2'd2: is_prot = (a >= `EE_PROT_HALF);
            default: is_prot = 1'b1;
        endcase
    endfunction : is_prot

    ////////////////////////////////////////////////////////////////////////
    // instruction decoder
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_CMD;
            addr <= 9'h000;
            is_rd <= 1'b0;
            sr_got <= 1'b0;
            sr_new <= `EE_BP_RST;
            prog_go <= 1'b0;
            prog_sr <= 1'b0;
            wel_set <= 1'b0;
            wel_clr <= 1'b0;
            tx_next <= 8'h00;
            mask <= 16'h0000;
        end else begin
            prog_go <= 1'b0;
            wel_set <= 1'b0;
            wel_clr <= 1'b0;
            if (cs_rise) begin
                // programming starts only at deselect, rechecking the pin [R6]
                state <= ST_CMD;
                sr_got <= 1'b0;
                if (wp_s && state == ST_WR && mask != 16'h0000) begin
                    prog_go <= 1'b1; // [R8]
                    prog_sr <= 1'b0;
                end else if (wp_s && sr_got) begin
                    prog_go <= 1'b1;
                    prog_sr <= 1'b1;
                end
            end else if (rx_take) begin
                case (state)
                    ST_CMD: begin
                        if (op == `EE_OP_RDSR) begin
                            tx_next <= {4'h0, status_o}; // [R12]
                            state <= ST_RDSR;
                        end else if (busy) begin
                            state <= ST_SKIP; // only status polling while busy
                        end else if ((op & `EE_OP_A8_MASK) == `EE_OP_READ) begin
                            addr[8] <= op[`EE_OP_A8_BIT];
                            is_rd <= 1'b1;
                            state <= ST_ADDR;
                        end else if ((op & `EE_OP_A8_MASK) == `EE_OP_WRITE) begin
                            addr[8] <= op[`EE_OP_A8_BIT];
                            is_rd <= 1'b0;
                            mask <= 16'h0000;
                            state <= (wel && wp_s) ? ST_ADDR : ST_SKIP; // [R15] [R6]
                        end else if (op == `EE_OP_WRSR) begin
                            state <= (wel && wp_s) ? ST_WRSR : ST_SKIP; // [R15] [R6]
                        end else begin
                            wel_set <= (op == `EE_OP_WREN);
                            wel_clr <= (op == `EE_OP_WRDI);
                            state <= ST_SKIP;
                        end
                    end
                    ST_ADDR: begin
                        addr[7:0] <= op;
                        if (is_rd) begin
                            tx_next <= mem[{addr[8], op}]; // [R3]
                            addr <= {addr[8], op} + 9'h001;
                            state <= ST_RD;
                        end else begin
                            // a whole page shares one protect level [R11] [R15]
                            state <= is_prot({addr[8], op}, bp) ? ST_SKIP : ST_WR;
                        end
                    end
                    ST_RD: begin
                        tx_next <= mem[addr]; // sequential read wraps at the top
                        addr <= addr + 9'h001;
                    end
                    ST_WR: begin
                        // bytes past the page end wrap inside the page [R9]
                        page_buf[addr[3:0]] <= op;
                        mask[addr[3:0]] <= 1'b1;
                        addr[3:0] <= addr[3:0] + 4'h1;
                    end
                    ST_RDSR: begin
                        tx_next <= {4'h0, status_o}; // [R12]
                    end
                    ST_WRSR: begin
                        sr_new <= op[3:2];
                        sr_got <= 1'b1;
                        state <= ST_SKIP;
                    end
                    ST_SKIP: begin
                        state <= ST_SKIP;
                    end
                    default: begin
                        state <= ST_CMD;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-timed program engine, one group of four bytes per timed cycle
    for (genvar k = 0; k < 4; k++) begin : g_quad
        assign quad_any[k] = |mask[4*k+3:4*k];
    end

    assign prog_tick = busy && (timer == WP_LAST);
    assign prog_done = prog_tick && ((quad_any & 4'(4'he << quad)) == 4'h0);

    // empty groups below the last used one still cost a timed cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy <= 1'b0;
            quad <= 2'd0;
            timer <= 20'd0;
        end else if (!busy) begin
            if (prog_go) begin
                busy <= 1'b1; // [R12]
                quad <= 2'd0;
                timer <= 20'd0;
            end
        end else if (prog_tick) begin
            timer <= 20'd0;
            if (prog_done || prog_sr) begin
                busy <= 1'b0;
            end else begin
                quad <= quad + 2'd1;
            end
        end else begin
            timer <= timer + 20'd1; // [R8]
        end
    end

    // array update: the one to four marked bytes of a group land together
    always_ff @(posedge mclk_i) begin
        if (prog_tick && !prog_sr) begin
            for (int i = 0; i < 4; i++) begin
                if (mask[{quad, 2'(i)}]) begin
                    mem[{addr[8:4], quad, 2'(i)}] <= page_buf[{quad, 2'(i)}]; // [R10] [R9]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status bits: latch cleared at end of any program operation
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wel <= 1'b0;
        end else if (wel_set) begin
            wel <= 1'b1;
        end else if (wel_clr || (prog_tick && (prog_done || prog_sr))) begin
            wel <= 1'b0; // [R7]
        end
    end

    // protect level takes effect when its own timed cycle ends
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp <= `EE_BP_RST;
        end else if (prog_tick && prog_sr) begin
            bp <= sr_new; // [R11]
        end
    end

    assign status_o = '{bp: bp, wel: wel, busy: busy};

endmodule : ee_top

// ===== test/ee_chk_sva.sv
module ee_chk_sva
    import ee_pkg::*;
#(
    parameter int WP_CYCLES = 20
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire ee_pkg::ee_status_t status_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////////////
    // length of the current busy stretch, so one assertion can bound it
    logic [31:0] busy_cnt;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= status_o.busy ? busy_cnt + 32'h1 : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_desel;
        cs_n_i [*3];
    endsequence
    sequence s_held;
        !hold_n_i [*3];
    endsequence
    sequence s_active;
        (!cs_n_i && hold_n_i) [*4];
    endsequence
    sequence s_prog_start;
        $rose(status_o.busy);
    endsequence
    sequence s_prog_end;
        $fell(status_o.busy);
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_oe_desel: assert property (s_desel |-> !so_oe_o)
        else $error("output enabled while deselected");
    a_oe_held: assert property (s_held |-> !so_oe_o)
        else $error("output enabled while suspended");
    a_oe_active: assert property (s_active |-> so_oe_o)
        else $error("output not enabled while selected");
    a_wp_refuse: assert property ((!wp_n_i) [*8] |-> !$rose(status_o.busy))
        else $error("program started with write protect low");
    a_prog_wel: assert property (s_prog_start |-> $past(status_o.wel))
        else $error("program started without write enable");
    a_prog_desel: assert property (s_prog_start |-> $past(cs_n_i, 2))
        else $error("program started before deselect");
    a_wel_end: assert property (s_prog_end |-> !status_o.wel)
        else $error("write enable left set after program");
    a_busy_span: assert property (s_prog_end |-> busy_cnt >= WP_CYCLES && busy_cnt <= 4 * WP_CYCLES + 2)
        else $error("program cycle length out of range");
    a_bp_update: assert property ($changed(status_o.bp) |-> $past(status_o.busy) || $past(status_o.busy, 2))
        else $error("protect level changed outside a program cycle");
    a_so_launch: assert property (($changed(so_o) && !cs_n_i && !$past(cs_n_i, 8))
        |-> $past(sck_i, 3) || $past(sck_i, 4) || $past(sck_i, 5))
        else $error("serial out changed away from a rising clock");
endmodule : ee_chk_sva

bind ee_top ee_chk_sva #(.WP_CYCLES(WP_CYCLES)) chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .status_o(status_o));

// ===== test/ee_host_model.sv
module ee_host_model (
    input wire logic mclk_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic hold_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 24; // 480 ns period keeps the link under 2.1 MHz

    // idle: deselected, clock low between frames
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic sel();
        cs_n_o <= 1'b0;
        tick(HALF);
    endtask : sel

    task automatic desel();
        tick(HALF);
        cs_n_o <= 1'b1;
        si_o <= ~si_o; // a released line must not look like the last bit
        tick(30); // 300 ns high before the next instruction
    endtask : desel

    // whole byte, msb first, launch on rise and sample on fall
    task automatic xfer(input logic [7:0] tx, input int hold_bit, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_o <= 1'b1;
            si_o <= tx[i];
            tick(HALF);
            sck_o <= 1'b0;
            rx[i] = so_i;
            tick(HALF);
            if (i == hold_bit) begin
                hold_n_o <= 1'b0;
                tick(HALF);
                // stray clocks with junk data while paused must be ignored
                repeat (2) begin
                    sck_o <= 1'b1;
                    si_o <= ~si_o;
                    tick(HALF);
                    sck_o <= 1'b0;
                    tick(HALF);
                end
                hold_n_o <= 1'b1;
                tick(HALF);
            end
        end
    endtask : xfer
endmodule : ee_host_model

// ===== test/ee_top_test.sv
`include "ee_cfg.svh"
`define EE_CHK(nm, exp, act) begin compares++; if ((act) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, act); end end

module ee_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ee_pkg::*;
    localparam int WPC = 1200; // long enough to poll status while busy
    logic mclk_i, nrst_i, wp_n, so, so_oe, cs_n, sck, si, hold_n;
    ee_status_t status;
    int num_errors, compares, n;
    logic [7:0] b;

    ee_top #(.WP_CYCLES(WPC)) dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .status_o(status));
    // an undriven line shows the inverse of the last bit, so sampling outside the drive window is caught
    ee_host_model host_u (.mclk_i(mclk_i), .so_i(so_oe ? so : ~so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
        .hold_n_o(hold_n));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic op1(input logic [7:0] code);
        logic [7:0] r;
        host_u.sel();
        host_u.xfer(code, -1, r);
        host_u.desel();
    endtask : op1

    task automatic wr(input logic [8:0] a, input int cnt, input logic [7:0] d);
        logic [7:0] r;
        host_u.sel();
        host_u.xfer(`EE_OP_WRITE | {4'h0, a[8], 3'h0}, -1, r);
        host_u.xfer(a[7:0], -1, r);
        for (int k = 0; k < cnt; k++) host_u.xfer(d + 8'(k), -1, r);
        host_u.desel();
    endtask : wr

    // leaves the device selected; the caller clocks data and deselects
    task automatic rd_start(input logic [8:0] a, input int hb);
        logic [7:0] r;
        host_u.sel();
        host_u.xfer(`EE_OP_READ | {4'h0, a[8], 3'h0}, -1, r);
        host_u.xfer(a[7:0], hb, r);
    endtask : rd_start

    task automatic wait_idle();
        for (int k = 0; k < 5 * WPC && status.busy !== 1'b0; k++) host_u.tick(1);
        `EE_CHK("idle", 1'b0, status.busy)
    endtask : wait_idle

    task automatic busy_len(output int c);
        c = 0;
        while (status.busy === 1'b1 && c < 10 * WPC) begin
            c++;
            host_u.tick(1);
        end
    endtask : busy_len

    task automatic wrsr(input logic [7:0] d);
        logic [7:0] r;
        op1(`EE_OP_WREN);
        host_u.sel();
        host_u.xfer(`EE_OP_WRSR, -1, r);
        host_u.xfer(d, -1, r);
        host_u.desel();
        wait_idle();
    endtask : wrsr

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_byte();
        op1(`EE_OP_WREN);
        `EE_CHK("wel set", 1'b1, status.wel)
        wr(9'h1a5, 1, 8'h5a);
        `EE_CHK("busy", 1'b1, status.busy)
        host_u.sel();
        host_u.xfer(`EE_OP_RDSR, -1, b);
        host_u.xfer(8'h00, -1, b);
        host_u.desel();
        `EE_CHK("polled busy", 1'b1, b[0])
        wait_idle();
        `EE_CHK("wel cleared", 1'b0, status.wel)
        rd_start(9'h1a5, -1);
        host_u.xfer(8'h00, -1, b);
        host_u.desel();
        `EE_CHK("byte 1a5", 8'h5a, b)
    endtask : t_byte

    task automatic t_refuse();
        host_u.xfer(`EE_OP_WREN, -1, b);
        `EE_CHK("wel unselected", 1'b0, status.wel)
        wr(9'h1a5, 1, 8'h11);
        `EE_CHK("busy no wel", 1'b0, status.busy)
        wp_n <= 1'b0;
        op1(`EE_OP_WREN);
        wr(9'h1a5, 1, 8'h22);
        `EE_CHK("busy wp low", 1'b0, status.busy)
        op1(`EE_OP_WRDI);
        wp_n <= 1'b1;
        rd_start(9'h1a5, -1);
        host_u.xfer(8'h00, -1, b);
        host_u.desel();
        `EE_CHK("byte kept", 8'h5a, b)
    endtask : t_refuse

    task automatic t_page();
        op1(`EE_OP_WREN);
        wr(9'h020, 16, 8'h80);
        busy_len(n);
        `EE_CHK("page time", 1'b1, n >= 4 * WPC - 30 && n <= 4 * WPC - 20)
        rd_start(9'h020, -1);
        for (int k = 0; k < 16; k++) begin
            host_u.xfer(8'h00, -1, b);
            `EE_CHK("page byte", 8'(8'h80 + k), b)
        end
        host_u.desel();
        op1(`EE_OP_WREN);
        wr(9'h033, 2, 8'hc0);
        busy_len(n);
        `EE_CHK("partial time", 1'b1, n >= 2 * WPC - 30 && n <= 2 * WPC - 20)
        rd_start(9'h034, -1);
        host_u.xfer(8'h00, -1, b);
        host_u.desel();
        `EE_CHK("partial byte", 8'hc1, b)
    endtask : t_page

    task automatic t_protect();
        // seed the byte that the protected write must leave alone
        op1(`EE_OP_WREN);
        wr(9'h180, 1, 8'h8c);
        wait_idle();
        for (int lv = 0; lv < 4; lv++) begin
            wrsr(8'(lv << 2));
            `EE_CHK("bp level", 2'(lv), status.bp)
        end
        op1(`EE_OP_WREN);
        wr(9'h000, 1, 8'h77);
        `EE_CHK("busy all protected", 1'b0, status.busy)
        op1(`EE_OP_WRDI);
        wrsr(8'h04);
        op1(`EE_OP_WREN);
        wr(9'h17f, 1, 8'h3c);
        wait_idle();
        op1(`EE_OP_WREN);
        wr(9'h180, 1, 8'h3d);
        `EE_CHK("busy upper quarter", 1'b0, status.busy)
        op1(`EE_OP_WRDI);
        rd_start(9'h17f, -1);
        host_u.xfer(8'h00, -1, b);
        `EE_CHK("byte 17f", 8'h3c, b)
        host_u.xfer(8'h00, -1, b);
        host_u.desel();
        `EE_CHK("byte 180", 8'h8c, b)
        wrsr(8'h00);
    endtask : t_protect

    task automatic t_hold();
        rd_start(9'h1a5, 4);
        host_u.xfer(8'h00, 5, b);
        host_u.desel();
        `EE_CHK("read across pause", 8'h5a, b)
    endtask : t_hold

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // cut a hang short well past the expected run length
    initial begin
        #1_000_000;
        num_errors++;
        wrap_up();
    end

    initial begin
        num_errors = 0;
        compares = 0;
        nrst_i = 1'b0;
        wp_n = 1'b1;
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        host_u.tick(3);
        `EE_CHK("status reset", 4'h0, status)
        `EE_CHK("oe idle", 1'b0, so_oe)
        t_byte();
        t_refuse();
        t_page();
        t_protect();
        t_hold();
        wrap_up();
    end
endmodule : ee_top_test
